// [rtl/dshpc_consts.vh]
// Purpose: shared constants of the dual slot hot-plug fault control
// Assumes: APB byte addresses, 32-bit data, 25 MHz pclk
// Notes: definitions only
`ifndef DSHPC_CONSTS_VH
`define DSHPC_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define DSHPC_OFF_STAT_A 8'h00
`define DSHPC_OFF_STAT_B 8'h04
`define DSHPC_OFF_COMMON 8'h08
`define DSHPC_OFF_FILT_A 8'h0C
`define DSHPC_OFF_FILT_B 8'h10
`define DSHPC_OFF_ADDR 8'h14
`define DSHPC_OFF_EVT 8'h18
`define DSHPC_OFF_EVT_MSK 8'h1C

// ****************************************
// Fault status field layout
// ****************************************
`define DSHPC_FW 7
`define DSHPC_MW 6
`define DSHPC_FB_5V 0
`define DSHPC_FB_3V 1
`define DSHPC_FB_12V 2
`define DSHPC_FB_M12V 3
`define DSHPC_FB_UV 4
`define DSHPC_FB_OT 5
`define DSHPC_FB_AUX 6

// ****************************************
// Common status bits
// ****************************************
`define DSHPC_CS_MASK 3
`define DSHPC_CS_GPA 4
`define DSHPC_CS_GPB 5
`define DSHPC_CS_MASK_RST 1'b0

// ****************************************
// Filter time and strap base
// ****************************************
`define DSHPC_TW 16
`define DSHPC_CLK_MHZ 25
`define DSHPC_FILT_RST_US 10
`define DSHPC_FILT_RST_CYC (`DSHPC_FILT_RST_US * `DSHPC_CLK_MHZ)
// Arbitrary serial base address high part
`define DSHPC_SMB_BASE 5'h0A
// Straps show their pulled-up level until captured
`define DSHPC_STRAP_RST 2'b11

`endif

// [rtl/dshpc_oc_timer.v]
// Purpose: current limit filter timer of one slot
// Assumes: limit input synchronous to pclk
// Notes: expiry is a level while the slot stays in limit
`timescale 1ns/1ns
`default_nettype none
`include "dshpc_consts.vh"

module dshpc_oc_timer (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Limit state and filter length
    input wire in_limit,
    input wire [`DSHPC_TW-1:0] filt_cyc,
    // Breaker trip request
    output reg expired_r
);

    reg [`DSHPC_TW-1:0] cnt_r;
    wire [`DSHPC_TW:0] cnt_inc = {1'b0, cnt_r} + {{`DSHPC_TW{1'b0}}, 1'b1};
    wire sat = (cnt_r >= filt_cyc);

    // ****************************************
    // Count cycles spent in current limit
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {`DSHPC_TW{1'b0}};
            expired_r <= 1'b0;
        end else begin
            cnt_r <= in_limit ? (sat ? cnt_r : cnt_inc[`DSHPC_TW-1:0]) : {`DSHPC_TW{1'b0}};
            expired_r <= in_limit & (cnt_inc >= {1'b0, filt_cyc});
        end
    end

endmodule
`default_nettype wire

// [rtl/dshpc_slot.v]
// Purpose: enables, fault latches and fault pin of one slot
// Assumes: trip inputs are levels synchronous to pclk
// Notes: a new trip wins over the latch clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "dshpc_consts.vh"

module dshpc_slot (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Enables
    input wire main_enable,
    input wire standby_rail_enable,
    // Fault causes
    input wire [`DSHPC_MW-1:0] main_trip,
    input wire aux_fault,
    // Switch controls
    output reg main_on_r,
    output reg aux_on_r,
    // Fault pin drive and new fault pulses
    output reg fault_drive_r,
    output reg [`DSHPC_FW-1:0] new_fault_r
);

    reg main_en_d_r;
    reg aux_en_d_r;
    reg [`DSHPC_MW-1:0] main_lat_r;
    reg aux_lat_r;

    // Edge detect on the enables
    wire main_rise = main_enable & ~main_en_d_r;
    wire aux_rise = standby_rail_enable & ~aux_en_d_r;

    // Latches clear on enable low, trips win
    wire [`DSHPC_MW-1:0] main_lat_nxt =
        main_trip | (main_enable ? main_lat_r : {`DSHPC_MW{1'b0}});
    wire aux_lat_nxt = aux_fault | (standby_rail_enable & aux_lat_r);
    wire main_flt = |main_lat_nxt;

    // ****************************************
    // Latches, switch state and fault pin
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_en_d_r <= 1'b0;
            aux_en_d_r <= 1'b0;
            main_lat_r <= {`DSHPC_MW{1'b0}};
            aux_lat_r <= 1'b0;
            main_on_r <= 1'b0;
            aux_on_r <= 1'b0;
            fault_drive_r <= 1'b0;
            new_fault_r <= {`DSHPC_FW{1'b0}};
        end else begin
            main_en_d_r <= main_enable;
            aux_en_d_r <= standby_rail_enable;
            main_lat_r <= main_lat_nxt;
            aux_lat_r <= aux_lat_nxt;
            // Rise turns on, low or any fault of its own side turns off
            main_on_r <= main_enable & ~main_flt & (main_on_r | main_rise);
            aux_on_r <= standby_rail_enable & ~aux_lat_nxt & (aux_on_r | aux_rise);
            // Pin held until every faulted side is released
            fault_drive_r <= main_flt | aux_lat_nxt;
            new_fault_r <= {aux_lat_nxt & ~aux_lat_r, main_lat_nxt & ~main_lat_r};
        end
    end

endmodule
`default_nettype wire

// [rtl/dshpc_top.v]
// Purpose: dual slot hot-plug fault control with APB registers
// Assumes: all inputs synchronous to pclk, APB zero wait state
// Notes: open-drain pins are given as output and enable pairs
`timescale 1ns/1ns
`default_nettype none
`include "dshpc_consts.vh"

module dshpc_top (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Slot enables, index 0 is slot A
    input wire [1:0] main_enable,
    input wire [1:0] standby_rail_enable,
    // Analog fault indications per slot, overtemp shared by both slots
    input wire [1:0] curr_limit_5v,
    input wire [1:0] curr_limit_3v,
    input wire [1:0] overcurrent_12v,
    input wire [1:0] overcurrent_m12v,
    input wire [1:0] input_undervolt,
    input wire [1:0] aux_fault,
    input wire overtemp,
    // General inputs and address straps
    input wire general_input_a,
    input wire general_input_b,
    input wire addr_select_hi,
    input wire addr_select_lo,
    // Switch controls per slot
    output wire [1:0] main_gate_on,
    output wire [1:0] standby_rail_output,
    // Open-drain fault pins per slot
    output wire [1:0] fault_pin_o,
    output wire [1:0] fault_pin_oe,
    // Open-drain interrupt pin and level interrupt
    output wire int_pin_o,
    output reg int_pin_oe,
    output wire irq,
    // Serial management address
    output wire [6:0] smb_address
);

    // ****************************************
    // Declarations
    // ****************************************
    // Per slot buses, slot A in the low part
    wire [2*`DSHPC_FW-1:0] stat_w;
    wire [2*`DSHPC_TW-1:0] filt_w;
    wire [2*`DSHPC_FW-1:0] new_fault_w;
    wire [1:0] expired_w;
    wire [1:0] fault_drive_w;
    wire [1:0] evt_w;
    // Register state
    reg irq_mask_bit_r;
    reg [1:0] evt_msk_r;
    reg [1:0] addr_sel_r;
    reg strap_done_r;
    // Read path
    reg [31:0] rd_nxt;
    reg hit;

    // APB phase decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire rd_done = access & ~pwrite;

    // Register strobes, taken at the access edge
    wire wr_common = wr & (paddr == `DSHPC_OFF_COMMON);
    wire wr_evt_msk = wr & (paddr == `DSHPC_OFF_EVT_MSK);
    wire rd_evt = rd_done & (paddr == `DSHPC_OFF_EVT);

    // ****************************************
    // Bus handshake
    // ****************************************
    // Zero wait, read data registered in setup
    assign pready = 1'b1;
    // Unmapped offsets answer with an error
    assign pslverr = access & ~hit;

    // ****************************************
    // Open-drain pins
    // ****************************************
    // Pins only pulled low, enable carries the state
    // Released level comes from the external pull-up
    assign fault_pin_o = 2'b00;
    assign fault_pin_oe = fault_drive_w;
    assign int_pin_o = 1'b0;

    // ****************************************
    // Per slot logic
    // ****************************************
    // One copy per slot, index 0 is slot A
    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_slot
            // Offsets and filter reset of this slot
            localparam [7:0] STAT_OFF = s ? `DSHPC_OFF_STAT_B : `DSHPC_OFF_STAT_A;
            localparam [7:0] FILT_OFF = s ? `DSHPC_OFF_FILT_B : `DSHPC_OFF_FILT_A;
            localparam [31:0] FILT_RST = `DSHPC_FILT_RST_CYC;
            reg [`DSHPC_FW-1:0] stat_r;
            reg [`DSHPC_TW-1:0] filt_r;
            reg evt_bit_r;
            wire [`DSHPC_MW-1:0] trip;
            // Filter runs while 5V or 3V is in limit
            wire in_limit = curr_limit_5v[s] | curr_limit_3v[s];
            wire [`DSHPC_FW-1:0] nf = new_fault_w[s*`DSHPC_FW +: `DSHPC_FW];
            wire echo = wr & (paddr == STAT_OFF);

            // Breaker trips of the main rails
            assign trip[`DSHPC_FB_5V] = expired_w[s] & curr_limit_5v[s];
            assign trip[`DSHPC_FB_3V] = expired_w[s] & curr_limit_3v[s];
            assign trip[`DSHPC_FB_12V] = overcurrent_12v[s];
            assign trip[`DSHPC_FB_M12V] = overcurrent_m12v[s];
            assign trip[`DSHPC_FB_UV] = input_undervolt[s];
            assign trip[`DSHPC_FB_OT] = overtemp;

            assign stat_w[s*`DSHPC_FW +: `DSHPC_FW] = stat_r;
            assign filt_w[s*`DSHPC_TW +: `DSHPC_TW] = filt_r;
            assign evt_w[s] = evt_bit_r;

            // Sticky fault status, set wins over echo clear
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stat_r <= {`DSHPC_FW{1'b0}};
                end else begin
                    stat_r <= nf | (stat_r & ~(echo ? pwdata[`DSHPC_FW-1:0] :
                        {`DSHPC_FW{1'b0}}));
                end
            end

            // Event flag, a read clears only what it reported, new events win
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    evt_bit_r <= 1'b0;
                end else begin
                    evt_bit_r <= (|nf) | (evt_bit_r & ~(rd_evt & prdata[s]));
                end
            end

            // Filter time per slot, in pclk cycles
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt_r <= FILT_RST[`DSHPC_TW-1:0];
                end else if (wr & (paddr == FILT_OFF)) begin
                    filt_r <= pwdata[`DSHPC_TW-1:0];
                end
            end

            // Current limit filter timer
            dshpc_oc_timer u_timer (
                .pclk(pclk),
                .presetn(presetn),
                .in_limit(in_limit),
                .filt_cyc(filt_r),
                .expired_r(expired_w[s])
            );

            // Enables, latches and fault pin
            dshpc_slot u_slot (
                .pclk(pclk),
                .presetn(presetn),
                .main_enable(main_enable[s]),
                .standby_rail_enable(standby_rail_enable[s]),
                .main_trip(trip),
                .aux_fault(aux_fault[s]),
                .main_on_r(main_gate_on[s]),
                .aux_on_r(standby_rail_output[s]),
                .fault_drive_r(fault_drive_w[s]),
                .new_fault_r(new_fault_w[s*`DSHPC_FW +: `DSHPC_FW])
            );
        end
    endgenerate

    // ****************************************
    // Common status and event registers
    // ****************************************
    // Interrupt pin mask bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_bit_r <= `DSHPC_CS_MASK_RST;
        end else if (wr_common) begin
            irq_mask_bit_r <= pwdata[`DSHPC_CS_MASK];
        end
    end

    // Event mask of the level interrupt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_msk_r <= 2'b00;
        end else if (wr_evt_msk) begin
            evt_msk_r <= pwdata[1:0];
        end
    end

    // Level interrupt from unmasked slot events
    assign irq = |(evt_w & evt_msk_r);

    // ****************************************
    // Interrupt pin
    // ****************************************
    // Any sticky fault bit of either slot
    wire any_stat = |stat_w;

    // Pin follows sticky status unless masked
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_pin_oe <= 1'b0;
        end else begin
            int_pin_oe <= ~irq_mask_bit_r & any_stat;
        end
    end

    // ****************************************
    // Address strap capture after reset release
    // ****************************************
    // Straps read once, a later change needs a reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_sel_r <= `DSHPC_STRAP_RST;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            addr_sel_r <= {addr_select_hi, addr_select_lo};
            strap_done_r <= 1'b1;
        end
    end

    assign smb_address = {`DSHPC_SMB_BASE, addr_sel_r};

    // ****************************************
    // Read multiplexer
    // ****************************************
    // Unused bits read as zero
    always @* begin
        rd_nxt = 32'h00000000;
        hit = 1'b1;
        case (paddr)
            `DSHPC_OFF_STAT_A: begin
                rd_nxt[`DSHPC_FW-1:0] = stat_w[`DSHPC_FW-1:0];
            end
            `DSHPC_OFF_STAT_B: begin
                rd_nxt[`DSHPC_FW-1:0] = stat_w[2*`DSHPC_FW-1:`DSHPC_FW];
            end
            `DSHPC_OFF_COMMON: begin
                rd_nxt[`DSHPC_CS_MASK] = irq_mask_bit_r;
                rd_nxt[`DSHPC_CS_GPA] = general_input_a;
                rd_nxt[`DSHPC_CS_GPB] = general_input_b;
            end
            `DSHPC_OFF_FILT_A: begin
                rd_nxt[`DSHPC_TW-1:0] = filt_w[`DSHPC_TW-1:0];
            end
            `DSHPC_OFF_FILT_B: begin
                rd_nxt[`DSHPC_TW-1:0] = filt_w[2*`DSHPC_TW-1:`DSHPC_TW];
            end
            `DSHPC_OFF_ADDR: begin
                rd_nxt[6:0] = smb_address;
            end
            `DSHPC_OFF_EVT: begin
                rd_nxt[1:0] = evt_w;
            end
            `DSHPC_OFF_EVT_MSK: begin
                rd_nxt[1:0] = evt_msk_r;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup & ~pwrite) begin
            prdata <= rd_nxt;
        end
    end

endmodule
`default_nettype wire

// [bench/dshpc_host.sv]
// Purpose: APB master model of the hot-plug host side
// Assumes: zero or more wait states, pready sampled at rising edges
// Notes: tasks are called by the bench through the instance
`timescale 1ns/1ns
`default_nettype none

module dshpc_host (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // One transfer; status echo writes also pass here
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// [bench/dshpc_top_properties.sv]
// Purpose: port checker of the hot-plug fault control
// Assumes: index 0 is slot A
// Notes: bound to the top module
`timescale 1ns/1ns
`default_nettype none
`include "dshpc_consts.vh"

module dshpc_chk (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire pslverr,
    // Slot inputs
    input wire [1:0] main_enable,
    input wire [1:0] standby_rail_enable,
    input wire [1:0] curr_limit_5v,
    input wire [1:0] curr_limit_3v,
    input wire [1:0] overcurrent_12v,
    input wire [1:0] overcurrent_m12v,
    input wire [1:0] input_undervolt,
    input wire [1:0] aux_fault,
    input wire overtemp,
    // Address straps
    input wire addr_select_hi,
    input wire addr_select_lo,
    // Outputs
    input wire [1:0] main_gate_on,
    input wire [1:0] standby_rail_output,
    input wire [1:0] fault_pin_oe,
    input wire int_pin_oe,
    input wire irq,
    input wire [6:0] smb_address
);
    // Immediate trip causes and every fault cause per slot
    wire [1:0] hard = overcurrent_12v | overcurrent_m12v | input_undervolt | {2{overtemp}};
    wire [1:0] any_c = hard | curr_limit_5v | curr_limit_3v | aux_fault;

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    genvar s;
    // Per slot relations
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_slot
            a_trip_gate_off: assert property (hard[s] |=> !main_gate_on[s])
                else $error("gate stayed on after trip");
            a_trip_pin_set: assert property ((hard[s] || aux_fault[s]) |=> fault_pin_oe[s])
                else $error("fault pin not set");
            a_low_main_off: assert property (!main_enable[s] |=> !main_gate_on[s])
                else $error("main rails on with enable low");
            a_low_aux_off: assert property (!standby_rail_enable[s] |=> !standby_rail_output[s])
                else $error("standby on with enable low");
            a_rise_main_on: assert property ($rose(main_enable[s]) && !fault_pin_oe[s] && !any_c[s]
                && !$past(any_c[s]) && !$past(any_c[s], 2) |=> main_gate_on[s])
                else $error("rising enable did not switch on");
            a_hold_both_en: assert property (fault_pin_oe[s] && main_enable[s]
                && standby_rail_enable[s] |=> fault_pin_oe[s])
                else $error("fault pin dropped with enables high");
            a_pin_release: assert property ((!main_enable[s] && !standby_rail_enable[s]
                && !any_c[s])[*3] |=> !fault_pin_oe[s])
                else $error("fault pin not released");
        end
    endgenerate

    a_smb_base: assert property ($past(presetn) |-> smb_address[6:2] == `DSHPC_SMB_BASE)
        else $error("serial base address wrong");
    a_strap_capture: assert property ($past(presetn) && !$past(presetn, 2)
        |-> smb_address[1:0] == $past({addr_select_hi, addr_select_lo}))
        else $error("address straps not captured");

    // Main scenarios reached
    c_fault_held: cover property (fault_pin_oe[0] && main_enable[0]);
    c_irq: cover property (irq);
    c_int_pin: cover property (int_pin_oe);
    c_slverr: cover property (pslverr);
endmodule

bind dshpc_top dshpc_chk chk_u (.pclk(pclk), .presetn(presetn), .pslverr(pslverr),
    .main_enable(main_enable), .standby_rail_enable(standby_rail_enable),
    .curr_limit_5v(curr_limit_5v), .curr_limit_3v(curr_limit_3v),
    .overcurrent_12v(overcurrent_12v), .overcurrent_m12v(overcurrent_m12v),
    .input_undervolt(input_undervolt), .aux_fault(aux_fault), .overtemp(overtemp),
    .addr_select_hi(addr_select_hi), .addr_select_lo(addr_select_lo),
    .main_gate_on(main_gate_on), .standby_rail_output(standby_rail_output),
    .fault_pin_oe(fault_pin_oe), .int_pin_oe(int_pin_oe), .irq(irq),
    .smb_address(smb_address));
`default_nettype wire

// [bench/dshpc_top_tb.sv]
// Purpose: self-checking bench of the hot-plug fault control
// Assumes: filter lengths reprogrammed to 4 cycles
// Notes: sticky status kept in an integer model
`timescale 1ns/1ns
`default_nettype none
`include "dshpc_consts.vh"

module dshpc_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [1:0] men = 2'h0, sen = 2'h0, cl5 = 2'h0, cl3 = 2'h0, oc12 = 2'h0;
    logic [1:0] ocm = 2'h0, uv = 2'h0, auxf = 2'h0, gp = 2'h0;
    logic ot = 1'b0, sel_hi = 1'b1, sel_lo = 1'b1, se, mask;
    wire psel, penable, pwrite, pready, pslverr, into, intoe, irq;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [1:0] gate, aux_out, fpo, foe;
    wire [6:0] smb;
    logic [31:0] rd;
    integer err_total = 0, comparisons = 0, seed = 29, i, k, s, sm;
    integer stat_m [0:1];

    dshpc_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dshpc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .main_enable(men), .standby_rail_enable(sen),
        .curr_limit_5v(cl5), .curr_limit_3v(cl3), .overcurrent_12v(oc12),
        .overcurrent_m12v(ocm), .input_undervolt(uv), .aux_fault(auxf), .overtemp(ot),
        .general_input_a(gp[0]), .general_input_b(gp[1]), .addr_select_hi(sel_hi),
        .addr_select_lo(sel_lo), .main_gate_on(gate), .standby_rail_output(aux_out),
        .fault_pin_o(fpo), .fault_pin_oe(foe), .int_pin_o(into), .int_pin_oe(intoe),
        .irq(irq), .smb_address(smb));

    // 25 MHz clock
    always #20 pclk = ~pclk;

    task results;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task cyc(input integer n);
        begin
            repeat (n) @(posedge pclk);
            #1;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        begin
            host_u.xfer(1'b1, a, d, rd, se);
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        begin
            host_u.xfer(1'b0, a, 32'h00000000, rd, se);
            chk(rd, exp);
        end
    endtask

    // Drive fault cause c of slot t, any c above 6 drives 12V and aux together
    task cause(input integer c, input integer t, input logic v);
        begin
            @(posedge pclk);
            case (c)
                0: cl5[t] <= v;
                1: cl3[t] <= v;
                2: oc12[t] <= v;
                3: ocm[t] <= v;
                4: uv[t] <= v;
                5: ot <= v;
                6: auxf[t] <= v;
                default: begin
                    oc12[t] <= v;
                    auxf[t] <= v;
                end
            endcase
        end
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        err_total = err_total + 1;
        results;
    end

    // Main sequence
    initial begin
        k = $random(seed);
        {sel_hi, sel_lo} = k[1:0];
        stat_m[0] = 0;
        stat_m[1] = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        rd_chk(`DSHPC_OFF_FILT_A, 32'h000000FA);
        rd_chk(8'h20, 32'h00000000);
        chk({31'h0, se}, 32'h00000001);
        rd_chk(`DSHPC_OFF_ADDR, {25'h0, `DSHPC_SMB_BASE, sel_hi, sel_lo});
        chk({25'h0, smb}, {25'h0, `DSHPC_SMB_BASE, sel_hi, sel_lo});
        chk({28'h0, fpo, into, pready}, 32'h00000001);
        wr(`DSHPC_OFF_FILT_A, 32'h00000004);
        wr(`DSHPC_OFF_FILT_B, 32'h00000004);
        wr(`DSHPC_OFF_EVT_MSK, 32'h00000003);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge pclk);
            k = $random(seed);
            gp <= k[1:0];
            cyc(1);
            rd_chk(`DSHPC_OFF_COMMON, {26'h0, gp, 4'h0});
        end
        $display("register test done");
        for (k = 0; k < 8; k = k + 1) begin
            s = $random(seed) & 1;
            mask = (k % 3 == 1);
            sm = (k == 5) ? 3 : (1 << s);
            wr(`DSHPC_OFF_COMMON, {28'h0, mask, 3'h0});
            rd_chk(`DSHPC_OFF_COMMON, {26'h0, gp, mask, 3'h0});
            @(posedge pclk);
            men <= 2'h3;
            sen <= 2'h3;
            cyc(3);
            chk({30'h0, gate}, 32'h00000003);
            chk({30'h0, aux_out}, 32'h00000003);
            cause(k, s, 1'b1);
            cyc(k < 2 ? 8 : 1);
            cause(k, s, 1'b0);
            cyc(3);
            for (i = 0; i < 2; i = i + 1) begin
                if (sm[i]) stat_m[i] = stat_m[i] | ((k == 7) ? 32'h44 : (32'h1 << k));
            end
            chk({30'h0, foe}, sm);
            chk({30'h0, gate}, (k == 6) ? 3 : (3 & ~sm));
            chk({30'h0, aux_out}, (k > 5) ? (3 & ~sm) : 3);
            rd_chk(s ? `DSHPC_OFF_STAT_B : `DSHPC_OFF_STAT_A, stat_m[s]);
            chk({31'h0, intoe}, {31'h0, !mask});
            chk({31'h0, irq}, 32'h00000001);
            rd_chk(`DSHPC_OFF_EVT, sm);
            cyc(1);
            chk({31'h0, irq}, 32'h00000000);
            @(posedge pclk);
            men <= 2'h0;
            cyc(4);
            chk({30'h0, foe}, (k > 5) ? sm : 0);
            @(posedge pclk);
            sen <= 2'h0;
            cyc(4);
            chk({30'h0, foe}, 32'h00000000);
            wr(`DSHPC_OFF_STAT_A, stat_m[0]);
            wr(`DSHPC_OFF_STAT_B, stat_m[1]);
            stat_m[0] = 0;
            stat_m[1] = 0;
            cyc(2);
            chk({31'h0, intoe}, 32'h00000000);
            $display("fault test %0d done", k);
        end
        results;
    end
endmodule
`default_nettype wire
